//--- rtl/itps_regs.vh
// Register map, reset values and field constants of the interrupt type and priority block
`ifndef ITPS_REGS_VH
`define ITPS_REGS_VH

`define ITPS_ADDR_TYPE_UPPER 32'h0022_3018
`define ITPS_ADDR_TYPE_LOWER 32'h0022_301C
`define ITPS_ADDR_LEVEL_REG7 32'h0022_3020
`define ITPS_ADDR_LEVEL_REG0 32'h0022_303C
`define ITPS_ADDR_STRIDE 32'h0000_0004
`define ITPS_RESET_TYPE 32'h0000_0000
`define ITPS_RESET_LEVEL 32'h0000_0000
`define ITPS_RESET_RDATA 32'h0000_0000
`define ITPS_NUM_SOURCES 64
`define ITPS_NUM_LEVEL_REGS 8
`define ITPS_LEVEL_W 4
`define ITPS_INDEX_W 6
`define ITPS_MASK_W 5
`define ITPS_MASK_OFF_BIT 4
`define ITPS_LEVEL_LOWEST 4'h0
`define ITPS_INDEX_NONE 6'h00

`endif

//--- rtl/itps_arbiter.v
// Normal interrupt arbiter: highest unmasked level wins, ties go to the highest source number
`timescale 1ns/1ps
`include "itps_regs.vh"

module itps_arbiter (
  input wire [`ITPS_NUM_SOURCES-1:0] pending_in,                   // Enabled normal-type sources
  input wire [`ITPS_NUM_SOURCES*`ITPS_LEVEL_W-1:0] levels_in,      // 4-bit level per source
  input wire [`ITPS_MASK_W-1:0] normal_level_mask_in,              // Mask threshold
  output reg winner_valid_out,                                     // Some source qualifies
  output reg [`ITPS_INDEX_W-1:0] winner_index_out,                 // Winning source number
  output reg [`ITPS_LEVEL_W-1:0] winner_level_out                  // Winning level
);

  integer i;
  reg [`ITPS_LEVEL_W-1:0] lvl;
  reg masked;

  always @* begin
    winner_valid_out = 1'b0;
    winner_index_out = `ITPS_INDEX_NONE;
    winner_level_out = `ITPS_LEVEL_LOWEST;
    lvl = `ITPS_LEVEL_LOWEST;
    masked = 1'b0;
    // Ascending scan with >= lets a later, higher-numbered source take a tie
    for (i = 0; i < `ITPS_NUM_SOURCES; i = i + 1) begin
      lvl = levels_in[i*`ITPS_LEVEL_W +: `ITPS_LEVEL_W];
      masked = !normal_level_mask_in[`ITPS_MASK_OFF_BIT] &&
               (lvl <= normal_level_mask_in[`ITPS_LEVEL_W-1:0]);
      if (pending_in[i] && !masked &&
          (!winner_valid_out || lvl >= winner_level_out)) begin
        winner_valid_out = 1'b1;
        winner_index_out = i[`ITPS_INDEX_W-1:0];
        winner_level_out = lvl;
      end
    end
  end

endmodule

//--- rtl/itps_top.v
// Interrupt type selection, normal priority registers and request generation
`timescale 1ns/1ps
`include "itps_regs.vh"

// Behaviour
// - Sixty-four type bits, upper and lower registers
// - Type registers reset to zero, all normal
// - Type one, asserted, enabled: fast request
// - Type zero source drives only normal request
// - Disabled sources drive neither request
// - Register accesses complete in one cycle
// - Higher level preempts lower level normal interrupt
// - Priority levels reset to lowest
// - Higher unmasked level wins simultaneous arbitration
// - Equal levels: highest source number wins
// - Four-bit level fields, eight per register
// - Levels never affect fast requests
// - Enables clear at reset block everything
module itps_top (
  input wire core_clk_in,                                 // 100 MHz clock
  input wire rst_in,                                      // Async reset, active high
  input wire bus_sel_in,                                  // Native bus access strobe
  input wire bus_wr_in,                                   // 1 write, 0 read
  input wire [31:0] bus_addr_in,                          // Byte address
  input wire [31:0] bus_wdata_in,                         // Write data
  input wire bus_super_in,                                // Master in supervisor mode
  input wire bus_word_in,                                 // Access is a full word
  output reg [31:0] bus_rdata_out,                        // Read data
  output reg bus_ack_out,                                 // Access done
  input wire [`ITPS_NUM_SOURCES-1:0] irq_source_in,       // Source asserted, same clock
  input wire [`ITPS_NUM_SOURCES-1:0] per_source_enable_in, // From enable registers
  input wire [`ITPS_MASK_W-1:0] normal_level_mask_in,     // Mask threshold
  output reg normal_request_n_out,                        // Normal request, active low
  output reg fast_request_n_out,                          // Fast request, active low
  output reg normal_winner_valid_out,                     // Arbitration has a winner
  output reg [`ITPS_INDEX_W-1:0] normal_winner_index_out, // Winning source number
  output reg [`ITPS_LEVEL_W-1:0] normal_winner_level_out  // Winning level
);

  reg [31:0] irq_type_select_upper_reg;
  reg [31:0] irq_type_select_lower_reg;
  wire [`ITPS_NUM_SOURCES-1:0] per_source_fast_select;
  wire [`ITPS_NUM_SOURCES*`ITPS_LEVEL_W-1:0] levels;
  wire [`ITPS_NUM_SOURCES-1:0] fast_pending;
  wire [`ITPS_NUM_SOURCES-1:0] normal_pending;
  wire [`ITPS_NUM_LEVEL_REGS-1:0] level_hit;
  wire access_ok;
  wire wr_ok;
  wire arb_valid;
  wire [`ITPS_INDEX_W-1:0] arb_index;
  wire [`ITPS_LEVEL_W-1:0] arb_level;
  reg [31:0] rdata_next;
  integer j;

  // Non-supervisor or partial-word accesses are acked but have no effect
  assign access_ok = bus_sel_in && bus_super_in && bus_word_in;
  assign wr_ok = access_ok && bus_wr_in;
  assign per_source_fast_select = {irq_type_select_upper_reg, irq_type_select_lower_reg};

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_type_select_upper_reg <= `ITPS_RESET_TYPE;
      irq_type_select_lower_reg <= `ITPS_RESET_TYPE;
    end else begin
      if (wr_ok && bus_addr_in == `ITPS_ADDR_TYPE_UPPER) begin
        irq_type_select_upper_reg <= bus_wdata_in;
      end
      if (wr_ok && bus_addr_in == `ITPS_ADDR_TYPE_LOWER) begin
        irq_type_select_lower_reg <= bus_wdata_in;
      end
    end
  end

  genvar k;
  generate
    for (k = 0; k < `ITPS_NUM_LEVEL_REGS; k = k + 1) begin : g_level
      // Register k holds sources 8k+7 down to 8k, one nibble each, highest at top
      reg [31:0] level_reg;
      assign level_hit[k] = bus_addr_in == `ITPS_ADDR_LEVEL_REG0 - `ITPS_ADDR_STRIDE * k;
      assign levels[k*32 +: 32] = level_reg;
      always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          level_reg <= `ITPS_RESET_LEVEL;
        end else if (wr_ok && level_hit[k]) begin
          level_reg <= bus_wdata_in;
        end
      end
    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < `ITPS_NUM_SOURCES; s = s + 1) begin : g_src
      // Enable gates both paths, so a cleared enable (its reset state) silences the source
      assign fast_pending[s] = irq_source_in[s] && per_source_enable_in[s] &&
                               per_source_fast_select[s];
      assign normal_pending[s] = irq_source_in[s] && per_source_enable_in[s] &&
                                 !per_source_fast_select[s];
    end
  endgenerate

  // Only normal-type sources reach the arbiter; fast requests ignore levels
  itps_arbiter u_arb (
    .pending_in(normal_pending),
    .levels_in(levels),
    .normal_level_mask_in(normal_level_mask_in),
    .winner_valid_out(arb_valid),
    .winner_index_out(arb_index),
    .winner_level_out(arb_level)
  );

  always @* begin
    rdata_next = `ITPS_RESET_RDATA;
    if (bus_addr_in == `ITPS_ADDR_TYPE_UPPER) begin
      rdata_next = irq_type_select_upper_reg;
    end else if (bus_addr_in == `ITPS_ADDR_TYPE_LOWER) begin
      rdata_next = irq_type_select_lower_reg;
    end
    for (j = 0; j < `ITPS_NUM_LEVEL_REGS; j = j + 1) begin
      if (level_hit[j]) begin
        rdata_next = levels[j*32 +: 32];
      end
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_rdata_out <= `ITPS_RESET_RDATA;
      bus_ack_out <= 1'b0;
      normal_request_n_out <= 1'b1;
      fast_request_n_out <= 1'b1;
      normal_winner_valid_out <= 1'b0;
      normal_winner_index_out <= `ITPS_INDEX_NONE;
      normal_winner_level_out <= `ITPS_LEVEL_LOWEST;
    end else begin
      bus_ack_out <= bus_sel_in;
      bus_rdata_out <= (access_ok && !bus_wr_in) ? rdata_next : `ITPS_RESET_RDATA;
      // Normal request follows the masked arbitration so a fully masked set stays quiet
      normal_request_n_out <= !arb_valid;
      fast_request_n_out <= !(|fast_pending);
      normal_winner_valid_out <= arb_valid;
      normal_winner_index_out <= arb_index;
      normal_winner_level_out <= arb_level;
    end
  end

endmodule

//--- bench/itps_core_model.sv
// Core-side model that samples the two active-low request lines
`timescale 1ns/1ps
module itps_core_model (
  input wire core_clk_in, // Core clock
  input wire irq_n_in, // Normal request, low active
  input wire fiq_n_in, // Fast request, low active
  output reg [1:0] taken_out // {fast, normal} seen by the core
);
  always @(posedge core_clk_in) begin
    taken_out <= {~fiq_n_in, ~irq_n_in};
  end
endmodule

//--- bench/itps_top_chk.sv
// Port assertions for the interrupt type and priority block
`timescale 1ns/1ps
module itps_top_chk (
  input wire core_clk_in,
  input wire rst_in,
  input wire bus_sel_in,
  input wire bus_super_in,
  input wire bus_word_in,
  input wire [63:0] irq_source_in,
  input wire [63:0] per_source_enable_in,
  input wire [4:0] normal_level_mask_in,
  input wire [31:0] bus_rdata_out,
  input wire bus_ack_out,
  input wire normal_request_n_out,
  input wire fast_request_n_out,
  input wire normal_winner_valid_out,
  input wire [5:0] normal_winner_index_out,
  input wire [3:0] normal_winner_level_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire [63:0] live = irq_source_in & per_source_enable_in;
  reg [63:0] live_q;
  // Winner index must point at a source that was live one edge earlier
  always @(posedge core_clk_in) begin
    live_q <= live;
  end
  sequence s_acc; bus_sel_in; endsequence
  sequence s_bad; bus_sel_in && !(bus_super_in && bus_word_in); endsequence
  AST_ACK: assert property (s_acc |=> bus_ack_out) else $error("ack missing");
  AST_ACK_ONLY: assert property (!bus_sel_in |=> !bus_ack_out) else $error("stray ack");
  AST_REFUSE: assert property (s_bad |=> bus_rdata_out == 32'h0000_0000) else $error("refused data");
  AST_IDLE: assert property (live == 64'h0 |=> normal_request_n_out && fast_request_n_out)
    else $error("request with no live source");
  AST_MASKALL: assert property (normal_level_mask_in == 5'h0f |=> normal_request_n_out)
    else $error("masked level requested");
  AST_WINREQ: assert property (normal_winner_valid_out == !normal_request_n_out)
    else $error("winner and request disagree");
  AST_WINSRC: assert property (normal_winner_valid_out |-> live_q[normal_winner_index_out])
    else $error("winner not live");
  AST_WINLVL: assert property (normal_winner_valid_out && !$past(normal_level_mask_in[4]) |->
    normal_winner_level_out > $past(normal_level_mask_in[3:0])) else $error("winner masked");
endmodule
bind itps_top itps_top_chk u_chk (.core_clk_in, .rst_in, .bus_sel_in, .bus_super_in, .bus_word_in,
  .irq_source_in, .per_source_enable_in, .normal_level_mask_in, .bus_rdata_out, .bus_ack_out,
  .normal_request_n_out, .fast_request_n_out, .normal_winner_valid_out, .normal_winner_index_out,
  .normal_winner_level_out);

//--- bench/tb_irq_type_select_and_normal_priority.sv
// Self-checking bench for the interrupt type and priority block
`timescale 1ns/1ps
`include "itps_regs.vh"
module tb_irq_type_select_and_normal_priority;
  reg clk = 0, rst = 1, sel = 0, wr = 0, sup = 1, word = 1;
  reg [31:0] addr = 0, wd = 0, rnd = 32'h0000_ea14;
  reg [63:0] src = 0, en = 0;
  reg [4:0] msk = 5'h10;
  wire [31:0] rd;
  wire ack, nreq, freq, wv;
  wire [5:0] wi;
  wire [3:0] wl;
  wire [1:0] taken;
  logic [31:0] expq[$];
  integer err_total = 0, check_count = 0;
  itps_top u_dut (.core_clk_in(clk), .rst_in(rst), .bus_sel_in(sel), .bus_wr_in(wr), .bus_addr_in(addr),
    .bus_wdata_in(wd), .bus_super_in(sup), .bus_word_in(word), .bus_rdata_out(rd), .bus_ack_out(ack),
    .irq_source_in(src), .per_source_enable_in(en), .normal_level_mask_in(msk), .normal_request_n_out(nreq),
    .fast_request_n_out(freq), .normal_winner_valid_out(wv), .normal_winner_index_out(wi),
    .normal_winner_level_out(wl));
  itps_core_model u_core (.core_clk_in(clk), .irq_n_in(nreq), .fiq_n_in(freq), .taken_out(taken));
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task cmp(input string what, input [31:0] e, input [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %0s expected %h seen %h", what, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // s is {supervisor, full word}; every access is acked, so every ack pops a note
  task acc(input w, input [31:0] a, input [31:0] d, input [1:0] s, input [31:0] e);
    @(negedge clk);
    {sel, wr, sup, word, addr, wd} = {1'b1, w, s, a, d};
    expq.push_back(e);
    @(negedge clk);
    sel = 0;
  endtask
  // Result seen two edges later: one in the block, one in the core model
  task irq(input [63:0] s, input [63:0] e, input [4:0] m, input [12:0] x);
    @(negedge clk);
    {src, en, msk} = {s, e, m};
    repeat (2) @(negedge clk);
    cmp("requests", {19'h0, x}, {19'h0, taken, wv, wi, wl});
  endtask
  // Sampled mid-cycle so ack and rdata are settled, not racing the edge that launches them
  always @(negedge clk) if (ack) cmp("rdata", expq.pop_front(), rd);
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    rnd = xs(rnd);
    acc(0, `ITPS_ADDR_TYPE_LOWER, 0, 3, 0);
    acc(0, `ITPS_ADDR_LEVEL_REG0, 0, 3, 0);
    acc(1, `ITPS_ADDR_TYPE_UPPER, rnd, 3, 0);
    acc(1, `ITPS_ADDR_TYPE_UPPER, 0, 1, 0);
    acc(1, `ITPS_ADDR_TYPE_UPPER, 0, 2, 0);
    acc(0, `ITPS_ADDR_TYPE_UPPER, 0, 2, 0);
    acc(0, `ITPS_ADDR_TYPE_UPPER, 0, 3, rnd);
    acc(0, 32'h0022_3040, 0, 3, 0);
    acc(1, `ITPS_ADDR_TYPE_UPPER, 0, 3, 0);
    acc(1, `ITPS_ADDR_TYPE_LOWER, 32'h0000_0020, 3, 0);
    acc(1, `ITPS_ADDR_LEVEL_REG0, 32'h0000_1010, 3, 0);
    acc(1, `ITPS_ADDR_LEVEL_REG7, 32'hf000_0000, 3, 0);
    irq(64'h20, '1, 5'h10, {2'b10, 1'b0, 6'h00, 4'h0});
    irq(64'he, '1, 5'h10, {2'b01, 1'b1, 6'h03, 4'h1});
    irq(64'he, '1, 5'h0f, 13'h0000);
    irq(64'h2c, '1, 5'h00, {2'b11, 1'b1, 6'h03, 4'h1});
    irq(64'h8000_0000_0000_0008, '1, 5'h0e, {2'b01, 1'b1, 6'h3f, 4'hf});
    irq(64'h2, '1, 5'h10, {2'b01, 1'b1, 6'h01, 4'h1});
    irq(64'h8000_0000_0000_0002, '1, 5'h10, {2'b01, 1'b1, 6'h3f, 4'hf});
    repeat (4) begin
      rnd = xs(rnd);
      irq({rnd, ~rnd}, 0, 5'h10, 13'h0000);
    end
    repeat (2) @(negedge clk);
    finish_test;
  end
endmodule
